//--- verilog/edpr_regs.svh
`ifndef EDPR_REGS_SVH
`define EDPR_REGS_SVH

`define EDPR_DEPTH      16
`define EDPR_ADDR_W     4
`define EDPR_DATA_W     8
`define EDPR_PAR_W      4
`define EDPR_CODE_W     13
`define EDPR_PORTS      2
`define EDPR_LATENCY    4
`define EDPR_FAULT_BIT  0
`define EDPR_PAR_LSB    8
`define EDPR_ALL_LSB    12
`define EDPR_MAX_POS    4'hc

`endif

//--- verilog/edpr_pkg.sv
`include "edpr_regs.svh"

package edpr_pkg;

    typedef logic [`EDPR_ADDR_W-1:0] edpr_addr_type;
    typedef logic [`EDPR_DATA_W-1:0] edpr_data_type;
    typedef logic [`EDPR_PAR_W-1:0]  edpr_par_type;
    typedef logic [`EDPR_CODE_W-1:0] edpr_code_type;

    typedef struct packed
    {
        edpr_addr_type addr;
        logic          wr;
        logic          rd;
    } edpr_ctrl_type;

    ////////////////////////////////////////////////////////////////////////////
    // Hamming check bits; data sits at codeword positions 3,5,6,7,9,10,11,12
    function automatic edpr_par_type edpr_hamming(input edpr_data_type d);
        edpr_par_type p;
        p[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
        p[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
        p[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
        p[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
        return p;
    endfunction : edpr_hamming

    // Data in the low bits so a flipped bit zero is a flipped data bit
    function automatic edpr_code_type edpr_encode(input edpr_data_type d);
        edpr_par_type p;
        p = edpr_hamming(d);
        return {^{p, d}, p, d};
    endfunction : edpr_encode

    function automatic edpr_data_type edpr_fix_mask(input edpr_par_type s);
        edpr_data_type m;
        case (s)
            4'h3:    m = 8'h01;
            4'h5:    m = 8'h02;
            4'h6:    m = 8'h04;
            4'h7:    m = 8'h08;
            4'h9:    m = 8'h10;
            4'ha:    m = 8'h20;
            4'hb:    m = 8'h40;
            4'hc:    m = 8'h80;
            default: m = 8'h00;
        endcase
        return m;
    endfunction : edpr_fix_mask

endpackage : edpr_pkg

//--- verilog/edpr_dec_if.sv
`timescale 1ns/1ps

interface edpr_dec_if;
    import edpr_pkg::*;

    edpr_code_type code;
    logic          load;
    edpr_data_type data;
    logic          fixed;
    logic          seen;
    logic          fatal;

    modport dec
    (
        input  code,
        input  load,
        output data,
        output fixed,
        output seen,
        output fatal
    );

    modport user
    (
        output code,
        output load,
        input  data,
        input  fixed,
        input  seen,
        input  fatal
    );
endinterface : edpr_dec_if

//--- verilog/edpr_decoder.sv
`timescale 1ns/1ps
`include "edpr_regs.svh"

module edpr_decoder
    import edpr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    edpr_dec_if.dec  bus
);

    edpr_par_type  syn;
    logic          odd;
    edpr_data_type nxt_data_ff;
    logic          nxt_fixed_ff;
    logic          nxt_fatal_ff;
    edpr_data_type data_ff;
    logic          fixed_ff;
    logic          fatal_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Plain expressions, not branches, so unknown input stays unknown
    always_comb
    begin
        syn          = edpr_hamming(bus.code[`EDPR_DATA_W-1:0])
                     ^ bus.code[`EDPR_ALL_LSB-1:`EDPR_PAR_LSB];
        odd          = ^bus.code;
        nxt_data_ff  = data_ff;
        nxt_fixed_ff = fixed_ff;
        nxt_fatal_ff = fatal_ff;
        if (bus.load)
        begin
            nxt_data_ff  = bus.code[`EDPR_DATA_W-1:0]
                         ^ (edpr_fix_mask(syn) & {`EDPR_DATA_W{odd}});
            nxt_fixed_ff = odd & (syn <= `EDPR_MAX_POS);
            nxt_fatal_ff = (~odd & (|syn)) | (odd & (syn > `EDPR_MAX_POS));
        end
    end

    // Outputs clear at reset, unlike the array's read output registers q_ff
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            data_ff  <= 8'h00;
            fixed_ff <= 1'b0;
            fatal_ff <= 1'b0;
        end
        else
        begin
            data_ff  <= nxt_data_ff;
            fixed_ff <= nxt_fixed_ff;
            fatal_ff <= nxt_fatal_ff;
        end
    end

    assign bus.data  = data_ff;
    assign bus.fixed = fixed_ff;
    assign bus.fatal = fatal_ff;
    assign bus.seen  = fixed_ff | fatal_ff;

endmodule : edpr_decoder

//--- verilog/edpr_top.sv
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "edpr_regs.svh"

module edpr_top
    import edpr_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           rst,
    input  wire logic           inject_port_a_lsb_fault,
    input  wire logic [3:0]     addr_a,
    input  wire logic [7:0]     wdata_a,
    input  wire logic           wr_en_a,
    input  wire logic           rd_en_a,
    input  wire logic [3:0]     addr_b,
    input  wire logic [7:0]     wdata_b,
    input  wire logic           wr_en_b,
    input  wire logic           rd_en_b,
    output wire logic [7:0]     port_a_decoded_output,
    output wire logic           port_a_fixed_flag,
    output wire logic           port_a_error_seen_flag,
    output wire logic           port_a_uncorrectable_flag,
    output wire logic [7:0]     port_b_decoded_output,
    output wire logic           port_b_fixed_flag,
    output wire logic           port_b_error_seen_flag,
    output wire logic           port_b_uncorrectable_flag
);

    localparam int NP = `EDPR_PORTS;

    // Index 0 is port A, index 1 is port B
    edpr_code_type enc_ff      [NP];
    edpr_code_type nxt_enc_ff  [NP];
    edpr_ctrl_type c1_ff       [NP];
    edpr_ctrl_type nxt_c1_ff   [NP];
    edpr_code_type code2_ff    [NP];
    edpr_code_type nxt_code2_ff[NP];
    edpr_ctrl_type c2_ff       [NP];
    edpr_ctrl_type nxt_c2_ff   [NP];
    edpr_code_type q_ff        [NP];
    edpr_code_type nxt_q_ff    [NP];
    logic          rd3_ff      [NP];
    logic          nxt_rd3_ff  [NP];
    edpr_code_type mem_ff      [`EDPR_DEPTH];
    edpr_code_type nxt_mem_ff  [`EDPR_DEPTH];

    ////////////////////////////////////////////////////////////////////////////
    // Encoder stage; control rides a matching register beside it
    always_comb
    begin
        nxt_enc_ff[0] = edpr_encode(wdata_a)
                      ^ (edpr_code_type'(inject_port_a_lsb_fault) << `EDPR_FAULT_BIT);
        nxt_enc_ff[1] = edpr_encode(wdata_b);
        nxt_c1_ff[0]  = '{addr: addr_a, wr: wr_en_a, rd: rd_en_a};
        nxt_c1_ff[1]  = '{addr: addr_b, wr: wr_en_b, rd: rd_en_b};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array: input register stage, then storage and read output register
    always_comb
    begin
        nxt_mem_ff = mem_ff;
        for (int p = 0; p < NP; p++)
        begin
            nxt_code2_ff[p] = enc_ff[p];
            nxt_c2_ff[p]    = c1_ff[p];
            nxt_rd3_ff[p]   = c2_ff[p].rd;
            nxt_q_ff[p]     = q_ff[p];
            if (c2_ff[p].rd)
            begin
                // Reads see the array before this edge's writes: old data
                nxt_q_ff[p] = mem_ff[c2_ff[p].addr];
            end
            if (c2_ff[p].wr)
            begin
                nxt_mem_ff[c2_ff[p].addr] = code2_ff[p];
            end
        end
        // Port A alone forwards its own write to its read
        if (c2_ff[0].rd && c2_ff[0].wr)
        begin
            nxt_q_ff[0] = code2_ff[0];
        end
        // Colliding writes store an unknown word, not a chosen winner
        if (c2_ff[0].wr && c2_ff[1].wr && (c2_ff[0].addr == c2_ff[1].addr))
        begin
            nxt_mem_ff[c2_ff[0].addr] = 'x;
        end
    end

    // Data path carries no reset: memory registers have no clear
    always_ff @(posedge ref_clk)
    begin
        enc_ff   <= nxt_enc_ff;
        code2_ff <= nxt_code2_ff;
        q_ff     <= nxt_q_ff;
        mem_ff   <= nxt_mem_ff;
    end

    // Control flags are reset so no write or read leaks out of reset
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int p = 0; p < NP; p++)
            begin
                c1_ff[p]  <= '0;
                c2_ff[p]  <= '0;
                rd3_ff[p] <= 1'b0;
            end
        end
        else
        begin
            c1_ff  <= nxt_c1_ff;
            c2_ff  <= nxt_c2_ff;
            rd3_ff <= nxt_rd3_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoders: fourth register stage
    edpr_dec_if dec_a ();
    edpr_dec_if dec_b ();

    assign dec_a.code = q_ff[0];
    assign dec_a.load = rd3_ff[0];
    assign dec_b.code = q_ff[1];
    assign dec_b.load = rd3_ff[1];

    edpr_decoder u_dec_a
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .bus     (dec_a.dec)
    );

    edpr_decoder u_dec_b
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .bus     (dec_b.dec)
    );

    assign port_a_decoded_output     = dec_a.data;
    assign port_a_fixed_flag         = dec_a.fixed;
    assign port_a_error_seen_flag    = dec_a.seen;
    assign port_a_uncorrectable_flag = dec_a.fatal;
    assign port_b_decoded_output     = dec_b.data;
    assign port_b_fixed_flag         = dec_b.fixed;
    assign port_b_error_seen_flag    = dec_b.seen;
    assign port_b_uncorrectable_flag = dec_b.fatal;

endmodule : edpr_top

//--- verification/edpr_user_model.sv
`timescale 1ns/1ps

module edpr_user_model
    import edpr_pkg::*;
(
    input  wire logic    ref_clk,
    output edpr_addr_type addr_a,
    output edpr_data_type wdata_a,
    output logic          wr_en_a,
    output logic          rd_en_a,
    output logic          inject_port_a_lsb_fault,
    output edpr_addr_type addr_b,
    output edpr_data_type wdata_b,
    output logic          wr_en_b,
    output logic          rd_en_b
);
    initial drive('0);

    // Both ports change together just after an edge and hold for the whole cycle
    task automatic drive(input logic [28:0] w);
        {addr_a, wdata_a, wr_en_a, rd_en_a, inject_port_a_lsb_fault,
         addr_b, wdata_b, wr_en_b, rd_en_b} <= w;
    endtask : drive
endmodule : edpr_user_model

//--- verification/edpr_top_assertions.sv
`timescale 1ns/1ps

module edpr_top_assertions
(
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       inject_port_a_lsb_fault,
    input wire logic [3:0] addr_a,
    input wire logic [7:0] wdata_a,
    input wire logic       wr_en_a,
    input wire logic       rd_en_a,
    input wire logic [3:0] addr_b,
    input wire logic [7:0] wdata_b,
    input wire logic       wr_en_b,
    input wire logic       rd_en_b,
    input wire logic [7:0] port_a_decoded_output,
    input wire logic       port_a_fixed_flag,
    input wire logic       port_a_error_seen_flag,
    input wire logic       port_a_uncorrectable_flag,
    input wire logic [7:0] port_b_decoded_output,
    input wire logic       port_b_fixed_flag,
    input wire logic       port_b_error_seen_flag,
    input wire logic       port_b_uncorrectable_flag
);
    wire logic [10:0] res_a = {port_a_decoded_output, port_a_fixed_flag,
                               port_a_error_seen_flag, port_a_uncorrectable_flag};
    wire logic [10:0] res_b = {port_b_decoded_output, port_b_fixed_flag,
                               port_b_error_seen_flag, port_b_uncorrectable_flag};

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_a_hold_idle: assert property (!$past(rd_en_a, 4) |-> res_a === $past(res_a))
        else $error("port A result moved with no read");
    a_b_hold_idle: assert property (!$past(rd_en_b, 4) |-> res_b === $past(res_b))
        else $error("port B result moved with no read");
    a_a_rdw_new: assert property ($past(wr_en_a && rd_en_a, 4)
        |-> port_a_decoded_output == $past(wdata_a, 4))
        else $error("port A read during write not new data");
    a_a_fault_fixed: assert property ($past(wr_en_a && rd_en_a && inject_port_a_lsb_fault, 4)
        |-> port_a_fixed_flag && port_a_error_seen_flag && !port_a_uncorrectable_flag)
        else $error("port A injected fault not reported as corrected");
    a_a_seen_or: assert property (port_a_error_seen_flag ===
        (port_a_fixed_flag | port_a_uncorrectable_flag)) else $error("port A seen flag wrong");
    a_b_seen_or: assert property (port_b_error_seen_flag ===
        (port_b_fixed_flag | port_b_uncorrectable_flag)) else $error("port B seen flag wrong");
    a_a_flags_excl: assert property (!(port_a_fixed_flag === 1'b1 &&
        port_a_uncorrectable_flag === 1'b1)) else $error("port A fixed and fatal together");
    a_b_flags_excl: assert property (!(port_b_fixed_flag === 1'b1 &&
        port_b_uncorrectable_flag === 1'b1)) else $error("port B fixed and fatal together");

    c_a_fixed: cover property (port_a_fixed_flag);
    c_b_fixed: cover property (port_b_fixed_flag);
    c_both_rdw: cover property (wr_en_a && rd_en_a && wr_en_b && rd_en_b && addr_a == addr_b);
endmodule : edpr_top_assertions

bind edpr_top edpr_top_assertions edpr_top_assertions_i (.*);

//--- verification/testbench.sv
`timescale 1ns/1ps
`include "edpr_regs.svh"

module testbench;
    import edpr_pkg::*;
    typedef struct {int due; edpr_data_type d; logic fx; logic ft;} edpr_exp_type;
    logic          ref_clk = 1'b0;
    logic          rst = 1'b1;
    edpr_addr_type addr_a, addr_b;
    edpr_data_type wdata_a, wdata_b, port_a_decoded_output, port_b_decoded_output;
    logic          wr_en_a, rd_en_a, wr_en_b, rd_en_b, inject_port_a_lsb_fault;
    logic          port_a_fixed_flag, port_a_error_seen_flag, port_a_uncorrectable_flag;
    logic          port_b_fixed_flag, port_b_error_seen_flag, port_b_uncorrectable_flag;
    int            cyc = 0;
    int            n_errors = 0;
    int            n_compared = 0;
    edpr_exp_type  qa[$];
    edpr_exp_type  qb[$];
    edpr_data_type mem[16];
    logic          bad[16];
    logic [28:0]   v;
    wire logic [10:0] res_a = {port_a_decoded_output, port_a_fixed_flag,
                               port_a_error_seen_flag, port_a_uncorrectable_flag};
    wire logic [10:0] res_b = {port_b_decoded_output, port_b_fixed_flag,
                               port_b_error_seen_flag, port_b_uncorrectable_flag};

    edpr_user_model edpr_user_model_i (.*);
    edpr_top        edpr_top_i (.*);

    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////////////
    // An unknown stored word must give unknown flags, hence b & ~b for fatal
    // Called just after an edge, before cyc has taken that edge's count, hence the 1
    function automatic edpr_exp_type mk(input edpr_data_type d, input logic b);
        return '{cyc + 1 + `EDPR_LATENCY, d, b, b & ~b};
    endfunction : mk

    // Reads see the array before this cycle's writes, except port A on its own write
    task automatic op(input logic [28:0] w);
        edpr_addr_type aa, ab;
        edpr_data_type da, db;
        logic          wa, ra, f, wb, rb;
        {aa, da, wa, ra, f, ab, db, wb, rb} = w;
        if (ra)
            qa.push_back(wa ? mk(da, f) : mk(mem[aa], bad[aa]));
        if (rb)
            qb.push_back(mk(mem[ab], bad[ab]));
        if (wa)
        begin
            mem[aa] = da;
            bad[aa] = f;
        end
        if (wb)
        begin
            mem[ab] = (wa && aa == ab) ? 'x : db;
            bad[ab] = (wa && aa == ab) ? 1'bx : 1'b0;
        end
        edpr_user_model_i.drive(w);
        @(posedge ref_clk);
    endtask : op

    task automatic chk(input string name, input edpr_exp_type e, input logic [10:0] seen);
        logic [10:0] want;
        want = {e.d, e.fx, e.fx | e.ft, e.ft};
        n_compared++;
        if (want !== seen)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, want, seen);
        end
    endtask : chk

    task automatic end_of_test;
        // A result that never showed up must not slip through as a pass
        if (qa.size() + qb.size() != 0)
        begin
            n_errors++;
            $display("Error pending_results expected 0 seen %0d", qa.size() + qb.size());
        end
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    always @(negedge ref_clk)
    begin
        if (qa.size() > 0 && qa[0].due == cyc)
            chk("port_a", qa.pop_front(), res_a);
        if (qb.size() > 0 && qb[0].due == cyc)
            chk("port_b", qb.pop_front(), res_b);
    end

    initial
    begin
        void'($urandom(37640));
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 16; i++)
            op({4'(i), 8'($urandom), 3'b100 | 3'(i % 2), 12'($urandom), 2'b00});
        op({4'h2, 8'haa, 3'b110, 4'h3, 8'hbb, 2'b11});
        op({4'h1, 8'hcc, 3'b100, 4'h1, 8'h00, 2'b01});
        op({4'h0, 8'hff, 3'b111, 4'h1, 8'h00, 2'b01});
        op({4'h0, 8'h00, 3'b010, 4'h0, 8'h00, 2'b01});
        for (int i = 0; i < 400; i++)
        begin
            v = 29'($urandom);
            if (v[16] && v[1] && v[28:25] == v[13:10])
                v[1] = 1'b0;
            op(v);
        end
        op({4'h0, 8'hdd, 3'b110, 4'h0, 8'hee, 2'b11});
        op({4'h0, 8'h00, 3'b010, 4'h0, 8'h00, 2'b01});
        repeat (8) op(29'($urandom) & ~29'h18003);
        end_of_test();
    end

    // The run needs about 440 cycles; allow 1000
    initial
    begin
        #50000;
        n_errors++;
        end_of_test();
    end
endmodule : testbench
